// ===== rtl/fault_guard_regs.svh
`ifndef FAULT_GUARD_REGS_SVH
`define FAULT_GUARD_REGS_SVH

// Blanking window after each driver turn-off edge, in nanoseconds.
`define FG_BLANK_NS 1000
// Least high time of the trip comparator, in nanoseconds.
`define FG_MIN_PULSE_NS 600
// System clock period in nanoseconds.
`define FG_CLK_PERIOD_NS 4
// Blanking count in cycles; a least time, so it rounds up.
`define FG_BLANK_CYC ((`FG_BLANK_NS + `FG_CLK_PERIOD_NS - 1) / `FG_CLK_PERIOD_NS)
// Pulse qualification count in cycles, rounded up.
`define FG_PULSE_CYC ((`FG_MIN_PULSE_NS + `FG_CLK_PERIOD_NS - 1) / `FG_CLK_PERIOD_NS)
// Successive qualified cycles needed before latching off.
`define FG_LATCH_COUNT 4
// Width of the timing counters.
`define FG_TMR_W 10

`endif

// ===== rtl/fault_guard_pkg.sv
package fault_guard_pkg;

    // Supervisory sequence states, Gray coded along the usual path.
    typedef enum logic [2:0] {
        ST_CHARGE = 3'b000,
        ST_RUN = 3'b001,
        ST_THERM_HOLD = 3'b011,
        ST_DISCHARGE = 3'b010,
        ST_LATCHED = 3'b110
    } seq_state_t;

    // Counter of successive qualified switching cycles.
    typedef logic [2:0] event_cnt_t;

endpackage

// ===== rtl/pulse_qualifier.sv
`timescale 1ns/1ns
`include "fault_guard_regs.svh"

// Turns the synchronised trip comparator into one pulse per qualified event.
module pulse_qualifier
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic drv_fall_i,
    input wire logic cmp_i,
    output logic event_o
);

    // Cycles since the last turn-off edge, saturating at the blank count.
    logic [`FG_TMR_W-1:0] blank_ff;
    logic [`FG_TMR_W-1:0] nxt_blank;
    // Cycles the comparator has been high after blanking.
    logic [`FG_TMR_W-1:0] high_ff;
    logic [`FG_TMR_W-1:0] nxt_high;
    // Keeps one event per assertion of the comparator.
    logic done_ff;
    logic nxt_done;
    logic event_ff;
    logic nxt_event;

    localparam logic [`FG_TMR_W-1:0] BLANK_CYC = `FG_TMR_W'(`FG_BLANK_CYC);
    localparam logic [`FG_TMR_W-1:0] PULSE_CYC = `FG_TMR_W'(`FG_PULSE_CYC);

    ////////////////////////////////////////////////////////////////////////
    // The comparator is ignored until the blank window ends, so leakage
    // ringing at turn-off never starts the width count.
    always_comb
    begin
        nxt_blank = blank_ff;
        nxt_high = high_ff;
        nxt_done = done_ff;
        nxt_event = 1'b0;
        if (drv_fall_i)
        begin
            // A new off time restarts blanking.
            nxt_blank = '0; // see R2
            nxt_high = '0;
            nxt_done = 1'b0;
        end
        else if (blank_ff != BLANK_CYC)
        begin
            // Still blanking.
            nxt_blank = blank_ff + `FG_TMR_W'(1); // see R2
        end
        else if (!cmp_i)
        begin
            // Short assertions are dropped here.
            nxt_high = '0; // see R3
            nxt_done = 1'b0;
        end
        else if (!done_ff)
        begin
            // Above the 3 V reference; count its high time.
            nxt_high = high_ff + `FG_TMR_W'(1); // see R1
            if (nxt_high == PULSE_CYC)
            begin
                nxt_event = 1'b1; // see R3
                nxt_done = 1'b1;
            end
        end
    end

    // Registers only.
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            blank_ff <= '0;
            high_ff <= '0;
            done_ff <= 1'b0;
            event_ff <= 1'b0;
        end
        else
        begin
            blank_ff <= nxt_blank;
            high_ff <= nxt_high;
            done_ff <= nxt_done;
            event_ff <= nxt_event;
        end
    end

    assign event_o = event_ff;

endmodule // pulse_qualifier

// ===== rtl/fault_latch_and_thermal_guard.sv
// Contract
// R1 - Trip candidate when pin exceeds 3 V.
// R2 - Ignore comparator 1 us after turn-off.
// R3 - Valid only if high at least 600 ns.
// R4 - Latch after four successive qualified cycles.
// R5 - Clean cycle clears the successive counter.
// R6 - Latched: no pulses, supply held at bias.
// R7 - Latch clears on mains loss or supply below 4 V. Code clears it on supply below 4 V only.
// R8 - Thermal trip while running stops pulses at once.
// R9 - After running thermal trip, discharge supply fully.
// R10 - Thermal trip elsewhere only pauses the sequence.
// R11 - Restart charges supply, runs above brown-out only.
`timescale 1ns/1ns
`include "fault_guard_regs.svh"

module fault_latch_and_thermal_guard
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic overvoltage_trip_i,
    input wire logic thermal_shutdown_i,
    input wire logic supply_turn_on_level_i,
    input wire logic supply_turn_off_level_i,
    input wire logic supply_below_4v_i,
    input wire logic line_above_brownout_i,
    input wire logic drv_fall_i,
    input wire logic cycle_start_i,
    output logic drive_enable_o,
    output logic supply_hold_level_o,
    output logic hv_startup_on_o,
    output logic line_cap_discharge_switch_o,
    output logic latched_o
);
    import fault_guard_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for the analog comparator levels.
    logic [5:0] sync1_ff;
    logic [5:0] sync2_ff;
    logic [5:0] raw_in;

    assign raw_in = {overvoltage_trip_i, thermal_shutdown_i,
                     supply_turn_on_level_i, supply_turn_off_level_i,
                     supply_below_4v_i, line_above_brownout_i};

    // Only the second stage is read by logic.
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sync1_ff <= 6'h00;
            sync2_ff <= 6'h00;
        end
        else
        begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
        end
    end

    logic trip_s;
    logic hot_s;
    logic vcc_on_s;
    logic vcc_off_s;
    logic vcc_low_s;
    logic bo_ok_s;

    assign trip_s = sync2_ff[5];
    assign hot_s = sync2_ff[4];
    assign vcc_on_s = sync2_ff[3];
    assign vcc_off_s = sync2_ff[2];
    assign vcc_low_s = sync2_ff[1];
    assign bo_ok_s = sync2_ff[0];

    ////////////////////////////////////////////////////////////////////////
    // Blanking and width qualification of the trip comparator.
    logic event_pulse;

    pulse_qualifier u_qual
    (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .drv_fall_i(drv_fall_i),
        .cmp_i(trip_s),
        .event_o(event_pulse)
    );

    ////////////////////////////////////////////////////////////////////////
    // Successive-event counting and the sequence state machine.
    seq_state_t state_ff;
    seq_state_t nxt_state;
    // Number of successive switching cycles with a qualified event.
    event_cnt_t cnt_ff;
    event_cnt_t nxt_cnt;
    // A qualified event was seen in the current switching cycle.
    logic seen_ff;
    logic nxt_seen;
    // Thermal trip came while running; restart needs a discharge.
    logic therm_run_ff;
    logic nxt_therm_run;

    localparam event_cnt_t LATCH_CNT = 3'(`FG_LATCH_COUNT);

    // The event counter only counts at cycle boundaries, so a single
    // noisy cycle never reaches the latch; the cost is one cycle of delay.
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_seen = seen_ff;
        nxt_therm_run = therm_run_ff;
        if (cycle_start_i)
        begin
            // A boundary consumes the flag. An event on this same edge is
            // counted below, so carrying it on would count it twice.
            nxt_seen = 1'b0; // see R5
        end
        else if (event_pulse)
        begin
            nxt_seen = 1'b1;
        end
        if (cycle_start_i && state_ff == ST_RUN)
        begin
            if (seen_ff || event_pulse)
            begin
                nxt_cnt = cnt_ff + 3'(1); // see R4
            end
            else
            begin
                nxt_cnt = '0; // see R5
            end
        end
        case (state_ff)
            ST_CHARGE:
            begin
                // Pauses while hot, resumes when cool.
                if (!hot_s && vcc_on_s && bo_ok_s) // see R10
                begin
                    nxt_state = ST_RUN; // see R11
                    nxt_cnt = '0;
                end
            end
            ST_RUN:
            begin
                if (nxt_cnt >= LATCH_CNT)
                begin
                    nxt_state = ST_LATCHED; // see R4
                end
                else if (hot_s && vcc_off_s)
                begin
                    nxt_state = ST_THERM_HOLD; // see R8
                    nxt_therm_run = 1'b1;
                end
                else if (!vcc_off_s)
                begin
                    // Undervoltage: recharge.
                    nxt_state = ST_CHARGE;
                end
            end
            ST_THERM_HOLD:
            begin
                if (!hot_s)
                begin
                    nxt_state = ST_DISCHARGE; // see R9
                end
            end
            ST_DISCHARGE:
            begin
                // Discharge pauses while hot.
                if (!hot_s && vcc_low_s) // see R10
                begin
                    nxt_state = ST_CHARGE; // see R9
                    nxt_therm_run = 1'b0;
                end
            end
            ST_LATCHED:
            begin
                // Only an external pull below 4 V or power loss releases.
                if (vcc_low_s)
                begin
                    nxt_state = ST_CHARGE; // see R7
                    nxt_cnt = '0;
                end
            end
            default:
            begin
                nxt_state = ST_CHARGE;
            end
        endcase
    end

    // Registers only.
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_ff <= ST_CHARGE;
            cnt_ff <= '0;
            seen_ff <= 1'b0;
            therm_run_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            seen_ff <= nxt_seen;
            therm_run_ff <= nxt_therm_run;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs decoded from the next state.
    logic drive_ff;
    logic hold_ff;
    logic hv_ff;
    logic dis_ff;
    logic latch_ff;

    // Outputs follow the next state so they change with the state itself.
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            drive_ff <= 1'b0;
            hold_ff <= 1'b0;
            hv_ff <= 1'b0;
            dis_ff <= 1'b0;
            latch_ff <= 1'b0;
        end
        else
        begin
            drive_ff <= (nxt_state == ST_RUN); // see R6
            hold_ff <= (nxt_state == ST_LATCHED); // see R6
            hv_ff <= (nxt_state == ST_CHARGE) && !hot_s; // see R11
            dis_ff <= (nxt_state == ST_DISCHARGE) && !hot_s; // see R9
            latch_ff <= (nxt_state == ST_LATCHED);
        end
    end

    assign drive_enable_o = drive_ff;
    assign supply_hold_level_o = hold_ff;
    assign hv_startup_on_o = hv_ff;
    assign line_cap_discharge_switch_o = dis_ff;
    assign latched_o = latch_ff;

endmodule // fault_latch_and_thermal_guard

// ===== dv/fault_guard_asserts.sv
`timescale 1ns/1ns
// Watches the guard's ports for the protection sequence relations.
module fault_guard_asserts
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic overvoltage_trip_i,
    input wire logic thermal_shutdown_i,
    input wire logic supply_turn_on_level_i,
    input wire logic supply_turn_off_level_i,
    input wire logic supply_below_4v_i,
    input wire logic line_above_brownout_i,
    input wire logic drv_fall_i,
    input wire logic cycle_start_i,
    input wire logic drive_enable_o,
    input wire logic supply_hold_level_o,
    input wire logic hv_startup_on_o,
    input wire logic line_cap_discharge_switch_o,
    input wire logic latched_o
);
    // One domain, so clock and reset are given once.
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////
    chk_latch_no_drive: assert property (
        latched_o |-> !drive_enable_o && supply_hold_level_o)
        else $error("latched while driving or not holding");
    chk_hold_only_latch: assert property (
        supply_hold_level_o |-> latched_o)
        else $error("hold level pulled while not latched");
    // Four samples cover the two-flop input synchroniser.
    chk_latch_persist: assert property (
        (latched_o && !supply_below_4v_i) [*4] |=> latched_o)
        else $error("latch dropped without supply pulled low");
    chk_latch_on_cycle: assert property (
        $rose(latched_o) |-> $past(cycle_start_i) ||
        $past(cycle_start_i, 2))
        else $error("latch set away from a cycle boundary");
    chk_latch_from_run: assert property (
        $rose(latched_o) |-> $past(drive_enable_o))
        else $error("latch set while not switching");
    chk_therm_stop: assert property (
        thermal_shutdown_i [*4] |=> !drive_enable_o)
        else $error("pulses allowed while over temperature");
    chk_therm_pause: assert property (
        thermal_shutdown_i [*4] |=>
        !hv_startup_on_o && !line_cap_discharge_switch_o)
        else $error("sequence not paused while over temperature");
    chk_dis_alone: assert property (
        line_cap_discharge_switch_o |->
        !hv_startup_on_o && !drive_enable_o && !latched_o)
        else $error("discharge overlaps another phase");
    chk_run_needs_line: assert property (
        $rose(drive_enable_o) |-> $past(line_above_brownout_i, 2) ||
        $past(line_above_brownout_i, 3))
        else $error("switching began below brown-out");
endmodule // fault_guard_asserts

bind fault_latch_and_thermal_guard fault_guard_asserts i_fault_guard_asserts
(
    .sys_clk_i, .rst_b_i, .overvoltage_trip_i, .thermal_shutdown_i,
    .supply_turn_on_level_i, .supply_turn_off_level_i, .supply_below_4v_i,
    .line_above_brownout_i, .drv_fall_i, .cycle_start_i, .drive_enable_o,
    .supply_hold_level_o, .hv_startup_on_o, .line_cap_discharge_switch_o,
    .latched_o
);

// ===== dv/supply_net_model.sv
`timescale 1ns/1ns
// Supply capacitor with its level comparators. One step per clock keeps
// charge and discharge short; real ramps take milliseconds.
module supply_net_model
#(
    parameter int ON_LVL = 120,
    parameter int OFF_LVL = 100,
    parameter int HOLD_LVL = 70,
    parameter int LOW_LVL = 40
)
(
    input wire logic sys_clk_i,
    input wire logic hv_on_i,
    input wire logic discharge_i,
    input wire logic hold_i,
    input wire logic force_low_i,
    output logic turn_on_o,
    output logic turn_off_o,
    output logic below_4v_o
);
    int vcc = 0; // Capacitor level in model steps.
    ////////////////////////////////////////
    // An outside pull wins over everything the device does.
    always @(posedge sys_clk_i)
    begin
        if (force_low_i)
            vcc <= 0;
        else if (discharge_i && vcc > 0)
            vcc <= vcc - 1;
        else if (hold_i)
            vcc <= HOLD_LVL;
        else if (hv_on_i && vcc < ON_LVL)
            vcc <= vcc + 1;
    end
    assign turn_on_o = vcc >= ON_LVL;
    assign turn_off_o = vcc > OFF_LVL;
    assign below_4v_o = vcc < LOW_LVL;
endmodule // supply_net_model

// ===== dv/fault_latch_and_thermal_guard_test.sv
`timescale 1ns/1ns
module fault_latch_and_thermal_guard_test;
    logic clk = 0, rst_b = 0, trip = 0, hot = 0, line_ok = 0;
    logic fall = 0, start = 0, force_low = 0;
    logic on_l, off_l, low4, drive, hold, hv, dis, latched;
    int fails = 0, n_tests = 0, cycles = 0;

    always #2 clk = ~clk;

    fault_latch_and_thermal_guard i_fault_latch_and_thermal_guard
    (
        .sys_clk_i(clk), .rst_b_i(rst_b), .overvoltage_trip_i(trip),
        .thermal_shutdown_i(hot), .supply_turn_on_level_i(on_l),
        .supply_turn_off_level_i(off_l), .supply_below_4v_i(low4),
        .line_above_brownout_i(line_ok), .drv_fall_i(fall),
        .cycle_start_i(start), .drive_enable_o(drive),
        .supply_hold_level_o(hold), .hv_startup_on_o(hv),
        .line_cap_discharge_switch_o(dis), .latched_o(latched)
    );
    supply_net_model i_supply_net_model
    (
        .sys_clk_i(clk), .hv_on_i(hv), .discharge_i(dis), .hold_i(hold),
        .force_low_i(force_low), .turn_on_o(on_l), .turn_off_o(off_l),
        .below_4v_o(low4)
    );
    ////////////////////////////////////////
    task automatic check(input string name, input logic seen,
                         input logic exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %b seen %b", name, exp, seen);
        end
    endtask
    // Inputs move 1 ns after a rising edge, except after tick(0), which only waits 1 ns.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Bounded wait for the start-up source or for switching.
    task automatic wait_for(input bit want_hv);
        for (int k = 0; k < 3000 && (want_hv ? hv : drive) !== 1'b1; k++)
            tick(1);
    endtask
    // One switching cycle: trip rises d cycles after turn-off, w wide.
    task automatic cyc(input int d, input int w);
        fall = 1;
        tick(1);
        fall = 0;
        tick(d);
        trip = 1;
        tick(w);
        trip = 0;
        tick(5);
        start = 1;
        tick(1);
        start = 0;
    endtask
    task automatic final_report();
        if (fails == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////
    task automatic t_start();
        check("drive_in_reset", drive, 0);
        rst_b = 1;
        tick(300);
        check("hv_charge", hv, 1);
        check("drive_brownout", drive, 0);
        line_ok = 1;
        wait_for(0);
        check("drive_run", drive, 1);
    endtask
    // Blanked or short trips break the run of successive cycles.
    task automatic t_count();
        for (int k = 0; k < 3; k++)
        begin
            repeat (3) cyc(260, 160);
            if (k == 0)
                cyc(0, 200);
            else if (k == 1)
                cyc(260, 140);
            check("latched_early", latched, 0);
        end
        cyc(260, 160);
        tick(2);
        check("latched", latched, 1);
        check("drive_latched", drive, 0);
        check("hold_latched", hold, 1);
    endtask
    task automatic t_latch();
        tick(400);
        check("latch_stays", latched, 1);
        force_low = 1;
        tick(8);
        force_low = 0;
        check("latch_cleared", latched, 0);
        check("hv_restart", hv, 1);
        wait_for(0);
    endtask
    task automatic t_therm();
        hot = 1;
        tick(4);
        check("drive_hot", drive, 0);
        tick(40);
        check("dis_hot", dis, 0);
        hot = 0;
        tick(4);
        check("dis_cool", dis, 1);
        tick(20);
        hot = 1;
        tick(4);
        check("dis_pause", dis, 0);
        hot = 0;
        tick(4);
        check("dis_resume", dis, 1);
        wait_for(1);
        hot = 1;
        tick(4);
        check("hv_pause", hv, 0);
        hot = 0;
        tick(4);
        check("hv_resume", hv, 1);
        wait_for(0);
        check("drive_back", drive, 1);
    endtask
    ////////////////////////////////////////
    // A hang counts as a failure and ends the run.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            final_report();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk);
        #1;
        t_start();
        t_count();
        t_latch();
        t_therm();
        final_report();
    end
endmodule // fault_latch_and_thermal_guard_test
